// ### rtl/timer_b_pkg.sv
package timer_b_pkg;
  // register byte addresses
  localparam logic [7:0] CTRL_A_OFS     = 8'h00;
  localparam logic [7:0] MODE_OFS       = 8'h04;
  localparam logic [7:0] EVENT_CTRL_OFS = 8'h08;
  localparam logic [7:0] INT_CTRL_OFS   = 8'h0C;
  localparam logic [7:0] FLAGS_OFS      = 8'h10;
  localparam logic [7:0] STATUS_OFS     = 8'h14;
  localparam logic [7:0] COUNT_OFS      = 8'h18;
  localparam logic [7:0] COMPARE_OFS    = 8'h1C;
  // control_a_reg fields
  localparam int ENABLE_BIT   = 0;
  localparam int CLOCK_SOURCE_FIELD_LSB   = 1;
  localparam int CLOCK_SOURCE_FIELD_W     = 3;
  // event_control_reg fields
  localparam int EDGE_BIT     = 0;
  localparam int TIMER_EVENT_FLAG_EN_BIT  = 4;
  // int/flag/status fields
  localparam int FLAG_BIT     = 0;
  localparam int RUN_BIT      = 0;
  // counter limits and reset values
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [15:0] COMPARE_RST  = 16'h0000;
  localparam logic [2:0]  CLOCK_SOURCE_FIELD_RST   = 3'h0;
  // clock sources
  localparam logic [2:0] CLK_DIV1  = 3'h0;
  localparam logic [2:0] CLK_DIV2  = 3'h1;
  localparam logic [2:0] CLK_TYPEA = 3'h2;
  localparam logic [2:0] CLK_EVENT = 3'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_PERIODIC = 3'b000,
    MODE_TIMEOUT  = 3'b001,
    MODE_CAPTURE  = 3'b010,
    MODE_FREQ     = 3'b011,
    MODE_PULSE    = 3'b100,
    MODE_FREQPW   = 3'b101,
    MODE_SINGLE   = 3'b110,
    MODE_PWM8     = 3'b111
  } mode_e;

  typedef enum logic [0:0] {
    TO_FROZEN  = 1'b0,
    TO_RUNNING = 1'b1
  } timeout_e;
endpackage

// ### rtl/type_b_timer.sv
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - count tick comes from prescaled peripheral clock, type A timer tick or event clock input.
// - type A source advances exactly on the type A timer's tick.
// - reset leaves the mode field at periodic interrupt mode.
// - software writes compare, then sets enable; counting follows clock source.
// - bottom is 0x0000, max 0xFFFF, top is the compare value.
// - periodic mode counts to compare value then restarts at zero.
// - periodic mode sets flag and emits event when count equals top.
// - compare below count: counter runs to max, wraps, restarts at zero.
// - time-out mode starts on first detected edge, stops on next.
// - edge bit chooses which polarity starts and which stops.
// - reaching top before stop edge sets flag and emits event.
// - after stop edge counter freezes, restarts on new start edge.
// - reads and run-bit writes while frozen change nothing.
// - capture mode counts zero to max continuously, ignoring compare.
// - capture event copies count to compare, sets flag, emits event.
// - capture edge selectable rising or falling.
// - capture mode: reading compare low byte clears the flag.
// - emitted event is a one peripheral clock pulse.
module type_b_timer
  import timer_b_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              type_a_tick_in,
  input  wire logic              event_in,
  input  wire logic              event_clk_in,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  output logic                   timer_event_out,
  output logic                   irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic              enable_reg;
  logic [2:0]        clock_source_field_reg;
  mode_e             mode_reg;
  logic              edge_reg;
  logic              timer_event_flag_en_reg;
  logic              int_en_reg;
  logic              timer_event_flag_reg;
  logic [15:0]       count_value_reg;
  logic [15:0]       compare_grab_reg;
  timeout_e          to_state_reg;
  logic              event_d_reg;
  logic              div_reg;
  logic              event_pulse_reg;
  logic              aw_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              w_full_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              ar_busy_reg;

  // word address compare helper
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    addr_is = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  function automatic logic known_addr(input logic [ADDR_W-1:0] a);
    known_addr = (a[ADDR_W-1:5] == '0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  logic wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  assign s_axi_awready_out = !aw_full_reg && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_full_reg && !s_axi_bvalid_out;
  assign wr_addr = aw_full_reg ? aw_addr_reg : s_axi_awaddr_in;
  assign wr_data = w_full_reg ? w_data_reg : s_axi_wdata_in;
  assign wr_strb = w_full_reg ? w_strb_reg : s_axi_wstrb_in;
  assign wr_go = (aw_full_reg || (s_axi_awvalid_in && s_axi_awready_out)) &&
                 (w_full_reg || (s_axi_wvalid_in && s_axi_wready_out));

  // address/data holding, either order
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
    end else if (wr_go) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
      end
    end
  end

  // write response
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= known_addr(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  logic rd_go;
  logic rd_cmp_low;
  logic [31:0] rd_word;

  assign s_axi_arready_out = !ar_busy_reg;
  assign rd_go = s_axi_arvalid_in && s_axi_arready_out;
  assign rd_cmp_low = rd_go && addr_is(s_axi_araddr_in, COMPARE_OFS);

  // read mux
  always_comb begin
    rd_word = 32'h00000000;
    if (addr_is(s_axi_araddr_in, CTRL_A_OFS)) begin
      rd_word[ENABLE_BIT] = enable_reg;
      rd_word[CLOCK_SOURCE_FIELD_LSB +: CLOCK_SOURCE_FIELD_W] = clock_source_field_reg;
    end else if (addr_is(s_axi_araddr_in, MODE_OFS)) begin
      rd_word[2:0] = mode_reg;
    end else if (addr_is(s_axi_araddr_in, EVENT_CTRL_OFS)) begin
      rd_word[EDGE_BIT] = edge_reg;
      rd_word[TIMER_EVENT_FLAG_EN_BIT] = timer_event_flag_en_reg;
    end else if (addr_is(s_axi_araddr_in, INT_CTRL_OFS)) begin
      rd_word[FLAG_BIT] = int_en_reg;
    end else if (addr_is(s_axi_araddr_in, FLAGS_OFS)) begin
      rd_word[FLAG_BIT] = timer_event_flag_reg;
    end else if (addr_is(s_axi_araddr_in, STATUS_OFS)) begin
      rd_word[RUN_BIT] = (to_state_reg == TO_RUNNING);
    end else if (addr_is(s_axi_araddr_in, COUNT_OFS)) begin
      rd_word[15:0] = count_value_reg;
    end else if (addr_is(s_axi_araddr_in, COMPARE_OFS)) begin
      rd_word[15:0] = compare_grab_reg;
    end
  end

  // read data register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ar_busy_reg      <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h00000000;
      s_axi_rresp_out  <= RESP_OKAY;
    end else if (rd_go) begin
      ar_busy_reg      <= 1'b1;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= rd_word;
      s_axi_rresp_out  <= known_addr(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      ar_busy_reg      <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic wr_ctrl, wr_mode, wr_evc, wr_int, wr_flags, wr_count, wr_cmp, wr_status;
  assign wr_ctrl   = wr_go && addr_is(wr_addr, CTRL_A_OFS) && wr_strb[0];
  assign wr_mode   = wr_go && addr_is(wr_addr, MODE_OFS) && wr_strb[0];
  assign wr_evc    = wr_go && addr_is(wr_addr, EVENT_CTRL_OFS) && wr_strb[0];
  assign wr_int    = wr_go && addr_is(wr_addr, INT_CTRL_OFS) && wr_strb[0];
  assign wr_flags  = wr_go && addr_is(wr_addr, FLAGS_OFS) && wr_strb[0];
  assign wr_status = wr_go && addr_is(wr_addr, STATUS_OFS) && wr_strb[0];
  assign wr_count  = wr_go && addr_is(wr_addr, COUNT_OFS);
  assign wr_cmp    = wr_go && addr_is(wr_addr, COMPARE_OFS);

  // control bits
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      enable_reg             <= 1'b0;
      clock_source_field_reg <= CLOCK_SOURCE_FIELD_RST;
      mode_reg               <= MODE_PERIODIC;
      edge_reg               <= 1'b0;
      timer_event_flag_en_reg            <= 1'b0;
      int_en_reg             <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        enable_reg             <= wr_data[ENABLE_BIT];
        clock_source_field_reg <= wr_data[CLOCK_SOURCE_FIELD_LSB +: CLOCK_SOURCE_FIELD_W];
      end
      if (wr_mode) mode_reg <= mode_e'(wr_data[2:0]);
      if (wr_evc) begin
        edge_reg    <= wr_data[EDGE_BIT];
        timer_event_flag_en_reg <= wr_data[TIMER_EVENT_FLAG_EN_BIT];
      end
      if (wr_int) int_en_reg <= wr_data[FLAG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tick selection and edge detection

  logic tick, ev_rise, ev_fall, start_edge, stop_edge, cap_edge;

  // divide-by-two prescaler
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) div_reg <= 1'b0;
    else div_reg <= !div_reg;
  end

  // tick source mux
  always_comb begin
    case (clock_source_field_reg)
      CLK_DIV1:  tick = 1'b1;
      CLK_DIV2:  tick = div_reg;
      CLK_TYPEA: tick = type_a_tick_in;
      CLK_EVENT: tick = event_clk_in;
      default:   tick = 1'b1;
    endcase
  end

  // input edge detector, pulse wider than a cycle assumed
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) event_d_reg <= 1'b0;
    else event_d_reg <= event_in;
  end

  assign ev_rise    = event_in && !event_d_reg;
  assign ev_fall    = !event_in && event_d_reg;
  assign start_edge = timer_event_flag_en_reg && (edge_reg ? ev_fall : ev_rise);
  assign stop_edge  = timer_event_flag_en_reg && (edge_reg ? ev_rise : ev_fall);
  assign cap_edge   = timer_event_flag_en_reg && (edge_reg ? ev_fall : ev_rise);

  ////////////////////////////////////////////////////////////////////////////
  // counter core

  logic step, hit_top, flag_set, capture_now;
  assign step = enable_reg && tick;
  assign hit_top = (count_value_reg == compare_grab_reg);
  assign capture_now = enable_reg && (mode_reg == MODE_CAPTURE) && cap_edge;

  // time-out run state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      to_state_reg <= TO_FROZEN;
    end else if (enable_reg && mode_reg == MODE_TIMEOUT) begin
      case (to_state_reg)
        TO_FROZEN:  if (start_edge) to_state_reg <= TO_RUNNING;
        TO_RUNNING: if (stop_edge) to_state_reg <= TO_FROZEN;
        default:    to_state_reg <= TO_FROZEN;
      endcase
    end else if (wr_status && mode_reg != MODE_TIMEOUT) begin
      to_state_reg <= timeout_e'(wr_data[RUN_BIT]);
    end
  end

  // count register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_value_reg <= COUNT_BOTTOM;
    end else if (wr_count) begin
      count_value_reg <= wr_data[15:0];
    end else if (mode_reg == MODE_TIMEOUT) begin
      if (enable_reg && to_state_reg == TO_FROZEN && start_edge)
        count_value_reg <= COUNT_BOTTOM;
      else if (step && to_state_reg == TO_RUNNING && !stop_edge)
        count_value_reg <= count_value_reg + 16'h0001;
    end else if (step) begin
      if (mode_reg == MODE_PERIODIC && hit_top)
        count_value_reg <= COUNT_BOTTOM;
      else
        count_value_reg <= count_value_reg + 16'h0001;
    end
  end

  // compare/capture register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) compare_grab_reg <= COMPARE_RST;
    else if (capture_now) compare_grab_reg <= count_value_reg;
    else if (wr_cmp) compare_grab_reg <= wr_data[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag, event and interrupt

  always_comb begin
    flag_set = 1'b0;
    if (step && hit_top && mode_reg == MODE_PERIODIC) flag_set = 1'b1;
    if (step && hit_top && mode_reg == MODE_TIMEOUT && to_state_reg == TO_RUNNING)
      flag_set = 1'b1;
    if (capture_now) flag_set = 1'b1;
  end

  // sticky flag, set wins over clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) timer_event_flag_reg <= 1'b0;
    else if (flag_set) timer_event_flag_reg <= 1'b1;
    else if (wr_flags && wr_data[FLAG_BIT]) timer_event_flag_reg <= 1'b0;
    else if (rd_cmp_low && mode_reg == MODE_CAPTURE) timer_event_flag_reg <= 1'b0;
  end

  // one-cycle event pulse
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) event_pulse_reg <= 1'b0;
    else event_pulse_reg <= flag_set;
  end

  assign timer_event_out = event_pulse_reg;
  assign irq_out = timer_event_flag_reg && int_en_reg;

endmodule

`default_nettype wire

// ### tb/type_b_timer_props.sv
`timescale 1ns/10ps
`default_nettype none
module type_b_timer_props
  import timer_b_pkg::*;
#(parameter int ADDR_W = 8) (
  input wire logic              clk_in,
  input wire logic              rst_in,
  input wire logic              s_axi_awvalid_in,
  input wire logic              s_axi_awready_out,
  input wire logic              s_axi_wvalid_in,
  input wire logic              s_axi_wready_out,
  input wire logic              s_axi_bvalid_out,
  input wire logic              s_axi_bready_in,
  input wire logic [1:0]        s_axi_bresp_out,
  input wire logic              s_axi_arvalid_in,
  input wire logic              s_axi_arready_out,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic              s_axi_rvalid_out,
  input wire logic              s_axi_rready_in,
  input wire logic [31:0]       s_axi_rdata_out,
  input wire logic [1:0]        s_axi_rresp_out,
  input wire logic              timer_event_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////
  // event output and bus answers
  a_event_pulse: assert property ($rose(timer_event_out) |=> $fell(timer_event_out))
    else $error("event pulse not one cycle");
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |=> s_axi_bvalid_out) else $error("no write response");
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  a_write_block: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken during response");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("no read response");
  a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
  a_read_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken during response");
  a_rvalid_drop: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
    else $error("read response repeated");
  a_unmapped_read: assert property (s_axi_arvalid_in && s_axi_arready_out
    && s_axi_araddr_in >= 8'h20 |=> s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == 32'h0)
    else $error("unmapped read not refused");
  c_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
  c_read: cover property (s_axi_rvalid_out && s_axi_rready_in);
  c_event: cover property (timer_event_out);
endmodule
bind type_b_timer type_b_timer_props #(.ADDR_W(ADDR_W)) props_u (.clk_in, .rst_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
  .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in,
  .s_axi_arready_out, .s_axi_araddr_in, .s_axi_rvalid_out, .s_axi_rready_in,
  .s_axi_rdata_out, .s_axi_rresp_out, .timer_event_out);
`default_nettype wire

// ### tb/event_route_model.sv
`timescale 1ns/10ps
`default_nettype none
module event_route_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic flip_req_in,
  input wire logic tick_en_in,
  output logic     event_out,
  output logic     tick_out
);
  // event level flips on request and then holds several cycles
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      event_out <= 1'b0;
    else if (flip_req_in)
      event_out <= ~event_out;
  end
  // event-channel tick every other cycle, only while tick_en_in is high
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      tick_out <= 1'b0;
    else
      tick_out <= tick_en_in & ~tick_out;
  end
endmodule
`default_nettype wire

// ### tb/type_b_timer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module type_b_timer_bench;
  import timer_b_pkg::*;
  logic        clk_in, rst_in, type_a_tick_in, event_in, event_clk_in, flip_req, tick_en;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, a, b, v;
  logic [3:0]  s_axi_wstrb_in;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, r;
  logic        s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
  logic        s_axi_rready_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic        s_axi_arready_out, s_axi_rvalid_out, timer_event_out, irq_out;
  int          k, s, e, c, ne, n_ev, n_checks, num_errors;
  type_b_timer dut_u (.*);
  event_route_model src_u (.clk_in, .rst_in, .flip_req_in(flip_req), .tick_en_in(tick_en),
    .event_out(event_in), .tick_out(event_clk_in));
  ////////////////////////////////////////
  // clock, type A tick every other cycle, event count
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // tick and event counter start from reset, single driver each
  always @(posedge clk_in) begin
    if (rst_in) begin
      type_a_tick_in <= 1'b0;
      n_ev <= 0;
    end else begin
      type_a_tick_in <= ~type_a_tick_in;
      n_ev <= n_ev + int'(timer_event_out);
    end
  end
  ////////////////////////////////////////
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task lim(input int n);
    if (n >= 64) begin
      chk("wait", 32'h0, 32'h1);
      tally_and_finish;
    end
  endtask
  // bus write: both channels offered together, bready raised on response
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    int n;
    s_axi_awaddr_in <= ad;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_in);
      if (s_axi_bready_in && s_axi_bvalid_out) break;
      if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (s_axi_bvalid_out) s_axi_bready_in <= 1'b1;
    end
    r = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
    lim(n);
  endtask
  // bus read: data taken at the edge where rready is sampled
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    int n;
    s_axi_araddr_in <= ad;
    s_axi_arvalid_in <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_in);
      if (s_axi_rready_in && s_axi_rvalid_out) break;
      if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      if (s_axi_rvalid_out) s_axi_rready_in <= 1'b1;
    end
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
    lim(n);
  endtask
  task flip_wait;
    flip_req <= 1'b1;
    @(posedge clk_in);
    flip_req <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask
  task wait_ev;
    for (k = 0; k < 2000; k++) begin
      @(posedge clk_in);
      if (timer_event_out) break;
    end
    if (k >= 2000) lim(64);
  endtask
  // expected event period for a clock source
  function automatic logic [31:0] period(input int top, input int src);
    return 32'((top + 1) * ((src == 0) ? 1 : 2));
  endfunction
  ////////////////////////////////////////
  initial begin
    {rst_in, s_axi_wstrb_in} = 5'h1F;
    {flip_req, tick_en, s_axi_awvalid_in, s_axi_wvalid_in} = 4'h0;
    {s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 3'h0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
    {n_checks, num_errors} = 0;
    void'($urandom(49084));
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(MODE_OFS, v);
    chk("mode reset", v, 32'h0);
    rd(COMPARE_OFS, v);
    chk("compare reset", v, {16'h0, COMPARE_RST});
    rd(8'h24, v);
    chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h24, 32'h1);
    chk("unmapped write", {30'h0, r}, {30'h0, RESP_SLVERR});
    $display("reset test done");
    // periodic mode from every clock source
    for (s = 0; s < 4; s++) begin
      c = 2 + int'($urandom % 6);
      tick_en <= (s == 3);
      wr(COMPARE_OFS, 32'(c));
      chk("write resp", {30'h0, r}, {30'h0, RESP_OKAY});
      wr(INT_CTRL_OFS, 32'h1);
      // a count kept from the last source may sit above the new top
      wr(COUNT_OFS, 32'h0);
      wr(CTRL_A_OFS, {28'h0, 3'(s), 1'b1});
      wait_ev;
      wait_ev;
      chk("period", 32'(k + 1), period(c, s));
      chk("irq set", {31'h0, irq_out}, 32'h1);
      wr(CTRL_A_OFS, 32'h0);
      rd(COUNT_OFS, a);
      rd(COUNT_OFS, b);
      chk("count kept", b, a);
      wr(FLAGS_OFS, 32'h1);
      chk("irq clear", {31'h0, irq_out}, 32'h0);
      $display("periodic source %0d done", s);
    end
    // capture on rising, then on falling edges
    for (e = 0; e < 2; e++) begin
      wr(MODE_OFS, {29'h0, MODE_CAPTURE});
      wr(EVENT_CTRL_OFS, 32'h10 | 32'(e));
      wr(COUNT_OFS, 32'h0);
      wr(CTRL_A_OFS, 32'h1);
      ne = n_ev;
      flip_wait;
      chk("rise capture", 32'(n_ev - ne), 32'(1 - e));
      rd(COUNT_OFS, a);
      flip_wait;
      chk("capture count", 32'(n_ev - ne), 32'h1);
      chk("capture irq", {31'h0, irq_out}, 32'h1);
      rd(COMPARE_OFS, v);
      chk("capture value", 32'(v > 32'h0 && (e == 1 ? v > a : v < a)), 32'h1);
      chk("read clears", {31'h0, irq_out}, 32'h0);
      wr(CTRL_A_OFS, 32'h0);
      $display("capture edge %0d done", e);
    end
    // time-out: stop before top, then overrun
    wr(MODE_OFS, {29'h0, MODE_TIMEOUT});
    wr(EVENT_CTRL_OFS, 32'h10);
    wr(COMPARE_OFS, 32'd40);
    wr(CTRL_A_OFS, 32'h1);
    ne = n_ev;
    flip_wait;
    flip_wait;
    rd(COUNT_OFS, a);
    chk("short run", 32'(a > 32'd4 && a < 32'd14), 32'h1);
    wr(STATUS_OFS, 32'h1);
    rd(STATUS_OFS, v);
    chk("run ignored", v, 32'h0);
    rd(COUNT_OFS, b);
    chk("frozen", b, a);
    chk("no timeout", 32'(n_ev - ne), 32'h0);
    flip_wait;
    repeat (48) @(posedge clk_in);
    chk("timeout event", 32'(n_ev - ne), 32'h1);
    $display("time-out test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
